// ### inc/tsc_map.svh
// Constants of the two-channel stripe controller
`ifndef TSC_MAP_SVH
`define TSC_MAP_SVH

`define TSC_CMD_IDENT      2'h0
`define TSC_CMD_WRITE      2'h2
`define TSC_CMD_READ       2'h3
`define TSC_SECTOR_BEATS   16
`define TSC_BEAT_CNT_W     5
`define TSC_CNT_MSB        15
`define TSC_SPACE_LSB      5
`define TSC_DATA_LSB       4
`define TSC_SPACE_FULL     11'h7FF
`define TSC_DATA_NONE      12'h000
`define TSC_SECT_W         48
`define TSC_USER_W         256
`define TSC_CH_W           128
`define TSC_ERR_W          32
`define TSC_CAP_RESET      48'h000000000000
`define TSC_ONE_SECT       48'h000000000001

`endif

// ### inc/tsc_pkg.sv
// Types of the two-channel stripe controller
package tsc_pkg;

   typedef enum logic [0:0] {
      TSC_IDLE,
      TSC_RUN
   } tsc_state_t;

   typedef struct packed {
      tsc_state_t         st;
      logic [1:0]         code;
      logic               active;
      logic [47:0]        left;
      logic [1:0]         req;
      logic [1:0][47:0]   addr;
      logic [1:0][47:0]   len;
      logic               busy;
      logic [47:0]        cap;
      logic               err;
      logic [1:0][31:0]   errw;
      logic               p1_v;
      logic               p1_wr;
      logic               p1_ch;
      logic [1:0]         tx_we;
      logic               rx_push;
      logic [255:0]       data;
   } tsc_ctrl_state_t;

   typedef struct packed {
      logic [4:0]         cnt;
      logic               act;
      logic               wr;
      logic               ch;
      logic               tx_pop;
      logic [1:0]         rx_rd;
   } tsc_burst_state_t;

endpackage

// ### core/tsc_burst.sv
// One-sector burst generator driving the FIFO read strobes
`timescale 1ns/1ps
`default_nettype none
`include "tsc_map.svh"

module tsc_burst #(
   parameter int BEATS = `TSC_SECTOR_BEATS
) (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        start_i,
   input  wire logic        write_i,
   input  wire logic        chan_i,
   output logic             busy_o,
   output logic             chan_o,
   output logic             tx_pop_o,
   output logic [1:0]       rx_rd_o
);

   tsc_pkg::tsc_burst_state_t s_r;
   tsc_pkg::tsc_burst_state_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (s_r.act) begin
         if (s_r.cnt == '0) begin
            s_nxt.act = 1'b0;
         end else begin
            s_nxt.cnt = s_r.cnt - 5'h01;
         end
      end else if (start_i) begin
         // Strobe held for a whole sector without gaps
         s_nxt.act = 1'b1;
         s_nxt.cnt = 5'(BEATS - 1);
         s_nxt.wr  = write_i;
         s_nxt.ch  = chan_i;
      end
      s_nxt.tx_pop   = s_nxt.act & s_nxt.wr;
      s_nxt.rx_rd[0] = s_nxt.act & ~s_nxt.wr & ~s_nxt.ch;
      s_nxt.rx_rd[1] = s_nxt.act & ~s_nxt.wr & s_nxt.ch;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign busy_o   = s_r.act;
   assign chan_o   = s_r.ch;
   assign tx_pop_o = s_r.tx_pop;
   assign rx_rd_o  = s_r.rx_rd;

endmodule
`default_nettype wire

// ### core/tsc_ctrl.sv
// Two-channel sector stripe controller between user FIFOs and two host cores
`timescale 1ns/1ps
`default_nettype none
`include "tsc_map.svh"

// Notes on behaviour
// - Data is striped per 512-byte sector; channel flips after every sector.
// - User path is 256 bits; channel buffers convert to 128 bits.
// - Each request is decoded; identify goes to both channels, read/write is split per channel and issued only to channels with sectors.
// - Channel busy lines are watched until the whole transfer ends.
// - Reset is active low, from the same source as the host cores.
// - Command 00 is identify, 10 is write, 11 is read.
// - No new request is accepted while busy is high.
// - Capacity reads zero after reset, then twice channel 0 capacity.
// - Error flag sets on any non-zero channel error word; only reset clears.
// - One 32-bit error word per channel, copied from each core.
// - Push to user receive FIFO only while level bits 15..5 not all ones.
// - Pop user transmit FIFO only while level bits 15..4 are non-zero.
// - Transmit FIFO empty flag is ignored; only its level is used.
// - Receive FIFO write data is valid in the cycle of its push.
// - One sector moves as sixteen consecutive strobe cycles.
// - Write sector needs one sector in user FIFO, two free in channel.
// - Read sector needs one sector in channel, two free in user FIFO.
module tsc_ctrl (
   input  wire logic                ref_clk_i,
   input  wire logic                rst_n_i,
   input  wire logic [1:0]          cmd_code_i,
   input  wire logic [47:0]         start_sector_i,
   input  wire logic [47:0]         sector_count_i,
   input  wire logic                cmd_request_i,
   output logic                     ctrl_busy_o,
   output logic [47:0]              total_capacity_o,
   output logic                     error_flag_o,
   output logic [1:0][31:0]         channel_error_word_o,
   input  wire logic [15:0]         rx_fifo_level_i,
   output logic                     rx_fifo_push_o,
   output logic [255:0]             rx_fifo_wdata_o,
   input  wire logic [15:0]         tx_fifo_level_i,
   input  wire logic                tx_fifo_empty_i,
   output logic                     tx_fifo_pop_o,
   input  wire logic [255:0]        tx_fifo_rdata_i,
   output logic [1:0]               ch_cmd_request_o,
   output logic [1:0][1:0]          ch_cmd_code_o,
   output logic [1:0][47:0]         ch_start_sector_o,
   output logic [1:0][47:0]         ch_sector_count_o,
   input  wire logic [1:0]          ch_busy_i,
   input  wire logic [47:0]         ch_capacity_i,
   input  wire logic [1:0][31:0]    ch_error_word_i,
   input  wire logic [1:0][15:0]    ch_tx_level_i,
   output logic [1:0]               ch_tx_push_o,
   output logic [255:0]             ch_tx_wdata_o,
   input  wire logic [1:0][15:0]    ch_rx_level_i,
   output logic [1:0]               ch_rx_pop_o,
   input  wire logic [1:0][255:0]   ch_rx_rdata_i
);

   logic                      rst_meta_r;
   logic                      rst_sync_r;
   tsc_pkg::tsc_ctrl_state_t  s_r;
   tsc_pkg::tsc_ctrl_state_t  s_nxt;
   logic                      burst_busy;
   logic                      burst_chan;
   logic                      burst_tx_pop;
   logic [1:0]                burst_rx_rd;
   logic                      burst_start;
   logic                      burst_write;
   logic                      beat;
   logic                      wr_room;
   logic                      rd_room;
   logic                      moved_all;
   logic [48:0]               addr_up;
   logic [48:0]               len_up;
   logic [47:0]               len_big;
   logic [47:0]               len_small;

   // Reset release through two stages; assertion stays asynchronous
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   // Rounded-up half of the start gives channel 0 its address; that of the count goes to the first sector's channel
   assign addr_up   = {1'b0, start_sector_i} + 49'h1;
   assign len_up    = {1'b0, sector_count_i} + 49'h1;
   assign len_big   = len_up[48:1];
   assign len_small = {1'b0, sector_count_i[47:1]};

   // Channel buffer counters follow the user FIFO conventions
   assign wr_room = (tx_fifo_level_i[`TSC_CNT_MSB:`TSC_DATA_LSB] != `TSC_DATA_NONE) &&
                    (ch_tx_level_i[s_r.active][`TSC_CNT_MSB:`TSC_SPACE_LSB]
                     != `TSC_SPACE_FULL);
   assign rd_room = (ch_rx_level_i[s_r.active][`TSC_CNT_MSB:`TSC_DATA_LSB]
                     != `TSC_DATA_NONE) &&
                    (rx_fifo_level_i[`TSC_CNT_MSB:`TSC_SPACE_LSB] != `TSC_SPACE_FULL);

   assign burst_write = (s_r.code == `TSC_CMD_WRITE);
   // Empty flag lags the level and would only add a redundant check
   assign burst_start = (s_r.st == tsc_pkg::TSC_RUN) && (s_r.left != '0) && !burst_busy &&
                        (burst_write ? wr_room : rd_room);
   assign beat        = burst_tx_pop | (|burst_rx_rd);

   // Last data word leaves the output stage before busy drops
   assign moved_all = (s_r.left == '0) && !burst_busy && !beat && !s_r.p1_v &&
                      (s_r.tx_we == 2'h0) && !s_r.rx_push;

   always_comb begin
      s_nxt = s_r;

      unique case (s_r.st)
         tsc_pkg::TSC_IDLE: begin
            if (cmd_request_i && !s_r.busy) begin
               unique case (cmd_code_i)
                  `TSC_CMD_IDENT: begin
                     s_nxt.st   = tsc_pkg::TSC_RUN;
                     s_nxt.busy = 1'b1;
                     s_nxt.code = cmd_code_i;
                     s_nxt.req  = 2'h3;
                     s_nxt.left = '0;
                     s_nxt.addr = '0;
                     s_nxt.len  = '0;
                  end
                  `TSC_CMD_WRITE,
                  `TSC_CMD_READ: begin
                     s_nxt.st      = tsc_pkg::TSC_RUN;
                     s_nxt.busy    = 1'b1;
                     s_nxt.code    = cmd_code_i;
                     s_nxt.left    = sector_count_i;
                     s_nxt.active  = start_sector_i[0];
                     s_nxt.addr[0] = addr_up[48:1];
                     s_nxt.addr[1] = {1'b0, start_sector_i[47:1]};
                     s_nxt.len[0]  = start_sector_i[0] ? len_small : len_big;
                     s_nxt.len[1]  = start_sector_i[0] ? len_big : len_small;
                     // A channel with nothing to do is left alone
                     s_nxt.req[0]  = (s_nxt.len[0] != '0);
                     s_nxt.req[1]  = (s_nxt.len[1] != '0);
                  end
                  default: begin
                     s_nxt.st = tsc_pkg::TSC_IDLE;
                  end
               endcase
            end
         end
         tsc_pkg::TSC_RUN: begin
            // Request held until the channel shows it has taken it
            for (int k = 0; k < 2; k++) begin
               if (s_r.req[k] && ch_busy_i[k]) begin
                  s_nxt.req[k] = 1'b0;
               end
            end
            if (burst_start) begin
               s_nxt.left   = s_r.left - `TSC_ONE_SECT;
               s_nxt.active = ~s_r.active;
            end
            if ((s_r.req == 2'h0) && (ch_busy_i == 2'h0) && moved_all) begin
               s_nxt.st   = tsc_pkg::TSC_IDLE;
               s_nxt.busy = 1'b0;
            end
         end
      endcase

      // Read data of either FIFO is valid one cycle after its strobe
      s_nxt.p1_v    = beat;
      s_nxt.p1_wr   = burst_tx_pop;
      s_nxt.p1_ch   = burst_chan;
      s_nxt.tx_we   = 2'h0;
      s_nxt.rx_push = 1'b0;
      if (s_r.p1_v) begin
         if (s_r.p1_wr) begin
            s_nxt.data           = tx_fifo_rdata_i;
            s_nxt.tx_we[s_r.p1_ch] = 1'b1;
         end else begin
            s_nxt.data    = ch_rx_rdata_i[s_r.p1_ch];
            s_nxt.rx_push = 1'b1;
         end
      end

      s_nxt.cap  = {ch_capacity_i[46:0], 1'b0};
      s_nxt.errw = ch_error_word_i;
      if ((ch_error_word_i[0] != '0) || (ch_error_word_i[1] != '0)) begin
         s_nxt.err = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         s_r     <= '0;
         s_r.cap <= `TSC_CAP_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   tsc_burst #(
      .BEATS (`TSC_SECTOR_BEATS)
   ) u_burst (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_sync_r),
      .start_i   (burst_start),
      .write_i   (burst_write),
      .chan_i    (s_r.active),
      .busy_o    (burst_busy),
      .chan_o    (burst_chan),
      .tx_pop_o  (burst_tx_pop),
      .rx_rd_o   (burst_rx_rd)
   );

   assign ctrl_busy_o          = s_r.busy;
   assign total_capacity_o     = s_r.cap;
   assign error_flag_o         = s_r.err;
   assign channel_error_word_o = s_r.errw;
   assign rx_fifo_push_o       = s_r.rx_push;
   assign rx_fifo_wdata_o      = s_r.data;
   assign tx_fifo_pop_o        = burst_tx_pop;
   assign ch_cmd_request_o     = s_r.req;
   assign ch_cmd_code_o        = {s_r.code, s_r.code};
   assign ch_start_sector_o    = s_r.addr;
   assign ch_sector_count_o    = s_r.len;
   assign ch_tx_push_o         = s_r.tx_we;
   assign ch_tx_wdata_o        = s_r.data;
   assign ch_rx_pop_o          = burst_rx_rd;

endmodule
`default_nettype wire

// ### sim/tsc_ctrl_checker.sv
// Port assertions for the stripe controller
`timescale 1ns/1ps
`default_nettype none
module tsc_ctrl_checker (
   input  wire logic             ref_clk_i,
   input  wire logic             rst_n_i,
   input  wire logic [1:0]       cmd_code_i,
   input  wire logic             cmd_request_i,
   input  wire logic             ctrl_busy_o,
   input  wire logic [47:0]      total_capacity_o,
   input  wire logic [47:0]      ch_capacity_i,
   input  wire logic             error_flag_o,
   input  wire logic [1:0][31:0] ch_error_word_i,
   input  wire logic [1:0][31:0] channel_error_word_o,
   input  wire logic             tx_fifo_pop_o,
   input  wire logic [15:0]      tx_fifo_level_i,
   input  wire logic             rx_fifo_push_o,
   input  wire logic [15:0]      rx_fifo_level_i,
   input  wire logic [255:0]     tx_fifo_rdata_i,
   input  wire logic [1:0]       ch_tx_push_o,
   input  wire logic [255:0]     ch_tx_wdata_o,
   input  wire logic [1:0]       ch_rx_pop_o,
   input  wire logic [1:0][255:0] ch_rx_rdata_i,
   input  wire logic [255:0]     rx_fifo_wdata_o
);
   logic [1:0] up_r;
   logic [3:0] pops_r;
   logic [3:0] push_r;
   logic       ok;
   // Internal reset copy lags the pin by two edges
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         up_r   <= 2'h0;
         pops_r <= 4'h0;
         push_r <= 4'h0;
      end else begin
         up_r   <= (up_r == 2'h3) ? up_r : up_r + 2'h1;
         pops_r <= pops_r + {3'h0, tx_fifo_pop_o};
         push_r <= push_r + {3'h0, rx_fifo_push_o};
      end
   end
   assign ok = rst_n_i && (up_r == 2'h3);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!ok);
   property p_accept;
      !ctrl_busy_o && cmd_request_i && cmd_code_i != 2'h1 |=> ctrl_busy_o;
   endproperty
   a_accept: assert property (p_accept) else $error("request not taken");
   property p_refuse;
      !ctrl_busy_o && cmd_request_i && cmd_code_i == 2'h1 |=> !ctrl_busy_o;
   endproperty
   a_refuse: assert property (p_refuse) else $error("bad code taken");
   property p_cap;
      1'b1 |=> total_capacity_o == {$past(ch_capacity_i[46:0]), 1'b0};
   endproperty
   a_cap: assert property (p_cap) else $error("capacity wrong");
   property p_err_set;
      ch_error_word_i != 64'h0 |=> error_flag_o;
   endproperty
   a_err_set: assert property (p_err_set) else $error("error flag not set");
   property p_err_hold;
      error_flag_o |=> error_flag_o;
   endproperty
   a_err_hold: assert property (p_err_hold) else $error("error flag dropped");
   property p_errw;
      1'b1 |=> channel_error_word_o == $past(ch_error_word_i);
   endproperty
   a_errw: assert property (p_errw) else $error("error word copy wrong");
   property p_pop16;
      $fell(tx_fifo_pop_o) |-> pops_r == 4'h0;
   endproperty
   a_pop16: assert property (p_pop16) else $error("pop run not whole sectors");
   property p_push16;
      $fell(rx_fifo_push_o) |-> push_r == 4'h0;
   endproperty
   a_push16: assert property (p_push16) else $error("push run not whole sectors");
   property p_pop_lvl;
      $rose(tx_fifo_pop_o) |-> $past(tx_fifo_level_i[15:4]) != 12'h000;
   endproperty
   a_pop_lvl: assert property (p_pop_lvl) else $error("pop without a sector");
   property p_push_lvl;
      $rose(rx_fifo_push_o) |-> $past(rx_fifo_level_i[15:5], 3) != 11'h7FF;
   endproperty
   a_push_lvl: assert property (p_push_lvl) else $error("push into full buffer");
   property p_wdata;
      ch_tx_push_o != 2'h0 |-> ch_tx_wdata_o == $past(tx_fifo_rdata_i);
   endproperty
   a_wdata: assert property (p_wdata) else $error("write data not passed");
   property p_one_ch;
      $onehot0(ch_tx_push_o) && $onehot0(ch_rx_pop_o);
   endproperty
   a_one_ch: assert property (p_one_ch) else $error("two channels active");
   property p_rdata;
      rx_fifo_push_o |-> rx_fifo_wdata_o == ($past(ch_rx_pop_o[1], 2) ?
         $past(ch_rx_rdata_i[1]) : $past(ch_rx_rdata_i[0]));
   endproperty
   a_rdata: assert property (p_rdata) else $error("read data not passed");
endmodule
bind tsc_ctrl tsc_ctrl_checker chk (.ref_clk_i, .rst_n_i, .cmd_code_i, .cmd_request_i,
   .ctrl_busy_o, .total_capacity_o, .ch_capacity_i, .error_flag_o, .ch_error_word_i,
   .channel_error_word_o, .tx_fifo_pop_o, .tx_fifo_level_i, .rx_fifo_push_o,
   .rx_fifo_level_i, .tx_fifo_rdata_i, .ch_tx_push_o, .ch_tx_wdata_o, .ch_rx_pop_o,
   .ch_rx_rdata_i, .rx_fifo_wdata_o);
`default_nettype wire

// ### sim/tsc_chan_model.sv
// Behavioural model of the two host channels and their buffers
`timescale 1ns/1ps
`default_nettype none
module tsc_chan_model (
   input  wire logic              ref_clk_i,
   input  wire logic              rst_n_i,
   input  wire logic [1:0]        req_i,
   input  wire logic              rx_fill_i,
   input  wire logic [1:0]        rx_pop_i,
   output logic [1:0]             busy_o,
   output logic [1:0][15:0]       tx_level_o,
   output logic [1:0][15:0]       rx_level_o,
   output logic [1:0][255:0]      rdata_o
);
   logic [1:0][7:0] hold_r;
   logic [15:0]     cnt_r;
   logic [1:0]      pop_q_r;
   assign tx_level_o = '0;
   assign rx_level_o = rx_fill_i ? {16'h0010, 16'h0010} : '0;
   always @(negedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hold_r  <= '0;
         pop_q_r <= 2'h0;
         busy_o  <= 2'h0;
         cnt_r   <= 16'h0;
         rdata_o <= '0;
      end else begin
         for (int k = 0; k < 2; k++) begin
            if (req_i[k] && hold_r[k] == 8'h0) begin
               hold_r[k] <= 8'h28;
            end else if (hold_r[k] != 8'h0) begin
               hold_r[k] <= hold_r[k] - 8'h01;
            end
            busy_o[k] <= req_i[k] || hold_r[k] > 8'h1;
            // Data only in the cycle after a pop, scrambled otherwise
            rdata_o[k] <= pop_q_r[k] ? {16{k[0], cnt_r[14:0]}} : ~rdata_o[k];
         end
         // Pop seen one cycle earlier, so data stands over the next rising edge
         pop_q_r <= rx_pop_i;
         cnt_r <= cnt_r + 16'h1;
      end
   end
endmodule
`default_nettype wire

// ### sim/test_tsc_ctrl.sv
// Self-checking bench of the stripe controller
`timescale 1ns/1ps
`default_nettype none
module test_tsc_ctrl;
   logic clk, rst_n, req, busy, errf, rxp, txp, fill, txp_q;
   logic [1:0] code, chreq, chbusy, chtxp, chrxp, c_req;
   logic [47:0] a, l, capo;
   logic [15:0] rx_lvl, tx_lvl;
   logic [255:0] tx_rd, rxwd, chtxwd;
   logic [1:0][31:0] errw, errwo;
   logic [1:0][1:0] chcode, c_code;
   logic [1:0][47:0] chaddr, chlen, c_a, c_l;
   logic [1:0][15:0] chtxl, chrxl;
   logic [1:0][255:0] chrxd;
   int n_fail, n_compared, tmo, n_rxp, n_pop, n_tp[2];
   logic seq[$];
   tsc_ctrl uut (.ref_clk_i(clk), .rst_n_i(rst_n), .cmd_code_i(code), .start_sector_i(a),
      .sector_count_i(l), .cmd_request_i(req), .ctrl_busy_o(busy), .total_capacity_o(capo),
      .error_flag_o(errf), .channel_error_word_o(errwo), .rx_fifo_level_i(rx_lvl),
      .rx_fifo_push_o(rxp), .rx_fifo_wdata_o(rxwd), .tx_fifo_level_i(tx_lvl),
      .tx_fifo_empty_i(1'b1), .tx_fifo_pop_o(txp), .tx_fifo_rdata_i(tx_rd),
      .ch_cmd_request_o(chreq), .ch_cmd_code_o(chcode), .ch_start_sector_o(chaddr),
      .ch_sector_count_o(chlen), .ch_busy_i(chbusy), .ch_capacity_i(48'h123456789ABC),
      .ch_error_word_i(errw), .ch_tx_level_i(chtxl), .ch_tx_push_o(chtxp),
      .ch_tx_wdata_o(chtxwd), .ch_rx_level_i(chrxl), .ch_rx_pop_o(chrxp),
      .ch_rx_rdata_i(chrxd));
   tsc_chan_model far (.ref_clk_i(clk), .rst_n_i(rst_n), .req_i(chreq), .rx_fill_i(fill),
      .rx_pop_i(chrxp), .busy_o(chbusy), .tx_level_o(chtxl), .rx_level_o(chrxl),
      .rdata_o(chrxd));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic results();
      $display("compared %0d, wrong %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic issue(input logic [1:0] c, input logic [47:0] sa, input logic [47:0] sl);
      @(negedge clk);
      code = c; a = sa; l = sl; req = 1'b1;
      @(negedge clk);
      req = 1'b0;
      c_req = chreq; c_code = chcode; c_a = chaddr; c_l = chlen;
      seq = {}; n_tp = '{0, 0}; n_rxp = 0; n_pop = 0;
   endtask
   task automatic fin();
      for (int i = 0; i < 3000 && busy === 1'b1; i++) @(negedge clk);
      chk("busy after end", 1'b0, busy);
   endtask
   always @(posedge clk) begin
      tmo++;
      if (tmo == 20000) begin
         n_fail++;
         results();
      end
      if (chtxp != 2'h0) seq.push_back(chtxp[1]);
      if (chrxp != 2'h0) seq.push_back(chrxp[1]);
      n_tp[0] += chtxp[0];
      n_tp[1] += chtxp[1];
      n_rxp += rxp;
      n_pop += txp;
   end
   // User transmit buffer answers one cycle after a pop
   always @(negedge clk) begin
      txp_q <= txp;
      tx_rd <= txp_q ? {8{tmo}} : ~tx_rd;
   end
   initial begin
      rst_n = 1'b0; req = 1'b0; code = 2'h0; a = '0; l = '0; fill = 1'b0;
      rx_lvl = 16'hFFC0; tx_lvl = 16'h000F; errw = '0; tx_rd = '0; txp_q = 1'b0;
      cyc(11);
      chk("capacity in reset", 48'h0, capo);
      cyc(1);
      rst_n = 1'b1;
      cyc(5);
      chk("capacity", 48'h2468ACF13578, capo);
      errw[1] = 32'h00000040;
      cyc(2);
      chk("error flag", 1'b1, errf);
      chk("error word", 32'h00000040, errwo[1]);
      errw = '0;
      cyc(4);
      chk("error flag held", 1'b1, errf);
      issue(2'h1, 48'h8, 48'h4);
      chk("bad code request", 2'h0, c_req);
      issue(2'h0, 48'h0, 48'h0);
      chk("ident req", 2'h3, c_req);
      chk("ident codes", 4'h0, c_code);
      fin();
      issue(2'h2, 48'h5, 48'h3);
      cyc(30);
      chk("pops under one sector", 0, n_pop);
      req = 1'b1; code = 2'h3;
      tx_lvl = 16'h0010;
      cyc(1);
      req = 1'b0;
      fin();
      chk("write req", 2'h3, c_req);
      chk("write codes", 4'hA, c_code);
      chk("ch0 addr", 48'h3, c_a[0]);
      chk("ch1 addr", 48'h2, c_a[1]);
      chk("ch0 len", 48'h1, c_l[0]);
      chk("ch1 len", 48'h2, c_l[1]);
      chk("ch0 pushes", 16, n_tp[0]);
      chk("ch1 pushes", 32, n_tp[1]);
      chk("no read ran", 0, n_rxp);
      for (int i = 0; i < 3; i++) chk("write stripe", i[0] ^ 1'b1, seq[16 * i]);
      fill = 1'b1;
      rx_lvl = 16'hFFE0;
      issue(2'h3, 48'h4, 48'h2);
      cyc(30);
      chk("push into full", 0, n_rxp);
      rx_lvl = 16'hFFC0;
      fin();
      chk("read codes", 4'hF, c_code);
      chk("rd ch0 addr", 48'h2, c_a[0]);
      chk("rd ch1 addr", 48'h2, c_a[1]);
      chk("read pushes", 32, n_rxp);
      for (int i = 0; i < 2; i++) chk("read stripe", i[0], seq[16 * i]);
      rst_n = 1'b0;
      cyc(2);
      chk("flag cleared", 1'b0, errf);
      results();
   end
endmodule
`default_nettype wire
